//--- rtl/rrx_pkg.sv
// constants, opcodes and register map for the return/reset/rotate executor
// ****************************************************************************
// Operation
// - software reset op pulses full device reset and clears reset_instruction_flag
// - interrupt_return_op pops stack into PC; one word, two instruction cycles
// - interrupt_return_op sets global_interrupt_enable, bit 7; no status flags change
// - literal_return_op loads its 8-bit literal into W; flags unchanged
// - literal_return_op pops return address into PC; one word, two cycles
// - subroutine return pops stack into PC; two cycles; W and flags untouched
// - rotate_left_carry_op shifts left, bit 7 to carry, old carry to bit 0
// - rotate destination 0 writes W, otherwise writes back the data register
// ****************************************************************************
package rrx_pkg;
  // ************************************************************************
  // timing
  // ************************************************************************
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned INSTR_HZ      = 25_000_000;
  localparam int unsigned ICYC_DIV      = CLK_HZ / INSTR_HZ;
  localparam logic [1:0]  ICYC_LAST     = 2'(ICYC_DIV - 1);

  // ************************************************************************
  // widths and opcodes
  // ************************************************************************
  localparam int unsigned PC_W          = 15;
  localparam int unsigned STK_DEPTH     = 16;
  localparam int unsigned STK_PTR_W     = 4;
  localparam int unsigned DMEM_DEPTH    = 128;
  localparam logic [13:0] OP_NOP        = 14'h0000;
  localparam logic [13:0] OP_RESET      = 14'h0001;
  localparam logic [13:0] OP_RETURN     = 14'h0008;
  localparam logic [13:0] OP_IRET       = 14'h0009;
  localparam logic [5:0]  OP_LRET_HI    = 6'h34;
  localparam logic [5:0]  OP_ROTL_HI    = 6'h0d;
  localparam int unsigned ROTL_DEST_BIT = 7;

  // ************************************************************************
  // register map (byte addresses) and fields
  // ************************************************************************
  localparam logic [11:0] ADDR_WREG     = 12'h000;
  localparam logic [11:0] ADDR_STATUS   = 12'h004;
  localparam logic [11:0] ADDR_INTCTL   = 12'h008;
  localparam logic [11:0] ADDR_PWRCTL   = 12'h00c;
  localparam logic [11:0] ADDR_PC       = 12'h010;
  localparam logic [11:0] ADDR_STKPTR   = 12'h014;
  localparam logic [11:0] ADDR_CTRL     = 12'h018;
  localparam logic [3:0]  ADDR_DMEM_HI  = 4'h2;
  localparam int unsigned CARRY_BIT     = 0;
  localparam int unsigned INT_EN_BIT    = 7;
  localparam int unsigned RST_FLAG_BIT  = 2;
  localparam int unsigned RUN_BIT       = 0;
  localparam logic        RST_FLAG_RST  = 1'b1;
  localparam logic        RUN_RST       = 1'b1;
  localparam logic        INT_EN_RST    = 1'b0;
  localparam logic [7:0]  WREG_RST      = 8'h00;
  localparam logic [14:0] PC_RST        = 15'h0000;

  typedef enum logic {RRX_ST_EXEC, RRX_ST_SECOND} rrx_state_e;
endpackage : rrx_pkg

//--- rtl/rrx_rotate.sv
// rotate-left-through-carry datapath
`timescale 1ns/100ps
module rrx_rotate (
  input  wire logic [7:0] din,
  input  wire logic       cin,
  output logic [7:0]      dout,
  output logic            cout
);
  assign dout = {din[6:0], cin};
  assign cout = din[7];
endmodule : rrx_rotate

//--- rtl/rrx_stack.sv
// hardware return stack, circular on over/underflow
`timescale 1ns/100ps
module rrx_stack
  import rrx_pkg::*;
(
  input  wire logic            clk_sys,
  input  wire logic            sys_rst,
  input  wire logic            clr,
  input  wire logic            push,
  input  wire logic            pop,
  input  wire logic [PC_W-1:0] push_data,
  output logic [PC_W-1:0]      top,
  output logic [STK_PTR_W-1:0] depth
);
  logic [PC_W-1:0]      mem [STK_DEPTH];
  logic [STK_PTR_W-1:0] sp_reg;
  logic [STK_PTR_W-1:0] sp_dec;

  assign sp_dec = sp_reg - 4'h1;
  assign top    = mem[sp_dec];
  assign depth  = sp_reg;

  // ************************************************************************
  // pointer
  // ************************************************************************
  always_ff @(posedge clk_sys) begin
    if (sys_rst || clr) begin
      sp_reg <= '0;
    end else if (push && !pop) begin
      sp_reg <= sp_reg + 4'h1;
    end else if (pop && !push) begin
      sp_reg <= sp_dec;
    end
  end

  // push and pop together replace the top entry
  always_ff @(posedge clk_sys) begin
    if (push && pop) begin
      mem[sp_dec] <= push_data;
    end else if (push) begin
      mem[sp_reg] <= push_data;
    end
  end
endmodule : rrx_stack

//--- rtl/rrx_core.sv
// instruction executor: returns, software reset, rotate left, no-op
`timescale 1ns/100ps
module rrx_core
  import rrx_pkg::*;
(
  input  wire logic            clk_sys,
  input  wire logic            sys_rst,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [11:0]     paddr,
  input  wire logic [31:0]     pwdata,
  output logic [31:0]          prdata,
  output logic                 pready,
  output logic                 pslverr,
  input  wire logic            instr_valid,
  input  wire logic [13:0]     instr_word,
  input  wire logic            stack_push,
  input  wire logic [PC_W-1:0] push_addr,
  output logic                 instr_taken,
  output logic [PC_W-1:0]      pc_out,
  output logic [7:0]           w_out,
  output logic                 carry_out,
  output logic                 global_interrupt_enable,
  output logic                 dev_rst_req
);
  // ************************************************************************
  // state
  // ************************************************************************
  rrx_state_e           state_reg;
  logic [1:0]           div_reg;
  logic                 icyc;
  logic [7:0]           w_reg;
  logic                 carry_reg;
  logic                 int_en_reg;
  logic                 rst_flag_reg;
  logic                 run_reg;
  logic [PC_W-1:0]      pc_reg;
  logic                 taken_reg;
  logic                 dev_rst_reg;
  logic [31:0]          prdata_reg;
  logic                 pready_reg;
  logic                 pslverr_reg;
  logic [7:0]           dmem [DMEM_DEPTH];

  // ************************************************************************
  // decode
  // ************************************************************************
  logic                 take;
  logic                 is_nop;
  logic                 is_reset;
  logic                 is_return;
  logic                 is_iret;
  logic                 is_lret;
  logic                 is_rotl;
  logic                 is_pop;
  logic                 rot_to_f;
  logic [6:0]           f_addr;
  logic [7:0]           rd_byte;
  logic [7:0]           rot_out;
  logic                 rot_carry;
  logic [PC_W-1:0]      stk_top;
  logic [STK_PTR_W-1:0] stk_depth;
  logic                 soft_rst;

  assign icyc      = (div_reg == ICYC_LAST);
  assign take      = (state_reg == RRX_ST_EXEC) && icyc && run_reg && instr_valid;
  assign is_nop    = (instr_word == OP_NOP);
  assign is_reset  = (instr_word == OP_RESET);
  assign is_return = (instr_word == OP_RETURN);
  assign is_iret   = (instr_word == OP_IRET);
  assign is_lret   = (instr_word[13:8] == OP_LRET_HI);
  assign is_rotl   = (instr_word[13:8] == OP_ROTL_HI);
  assign is_pop    = is_return || is_iret || is_lret;
  assign rot_to_f  = instr_word[ROTL_DEST_BIT];
  assign f_addr    = instr_word[6:0];
  assign rd_byte   = dmem[f_addr];
  assign soft_rst  = take && is_reset;

  rrx_rotate u_rotate (
    .din  (rd_byte),
    .cin  (carry_reg),
    .dout (rot_out),
    .cout (rot_carry)
  );

  rrx_stack u_stack (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .clr       (soft_rst),
    .push      (stack_push),
    .pop       (take && is_pop),
    .push_data (push_addr),
    .top       (stk_top),
    .depth     (stk_depth)
  );

  // ************************************************************************
  // apb access strobes
  // ************************************************************************
  logic                 acc_done;
  logic                 apb_wr;
  logic                 dmem_hit;
  logic                 reg_hit;

  // one wait state so read data and errors come from flops
  assign acc_done = psel && penable && pready_reg;
  assign apb_wr   = acc_done && pwrite;
  // data bytes sit at 0x200..0x3fc, so bits 11:9 carry the upper nibble's top three bits
  assign dmem_hit = (paddr[11:9] == ADDR_DMEM_HI[3:1]) && (paddr[1:0] == 2'h0);
  always_comb begin
    case (paddr)
      ADDR_WREG, ADDR_STATUS, ADDR_INTCTL, ADDR_PWRCTL,
      ADDR_PC, ADDR_STKPTR, ADDR_CTRL: reg_hit = 1'b1;
      default:                         reg_hit = 1'b0;
    endcase
  end

  // ************************************************************************
  // instruction-cycle divider and sequencer
  // ************************************************************************
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      div_reg <= '0;
    end else begin
      div_reg <= icyc ? 2'h0 : div_reg + 2'h1;
    end
  end

  // second cycle of a return is the flush slot: no word is taken
  always_ff @(posedge clk_sys) begin
    if (sys_rst || soft_rst) begin
      state_reg <= RRX_ST_EXEC;
    end else begin
      case (state_reg)
        RRX_ST_EXEC: begin
          if (take && is_pop) begin
            state_reg <= RRX_ST_SECOND;
          end
        end
        RRX_ST_SECOND: begin
          if (icyc) begin
            state_reg <= RRX_ST_EXEC;
          end
        end
        default: state_reg <= RRX_ST_EXEC;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      taken_reg   <= 1'b0;
      dev_rst_reg <= 1'b0;
    end else begin
      taken_reg   <= take;
      dev_rst_reg <= soft_rst;
    end
  end

  // ************************************************************************
  // program counter
  // ************************************************************************
  always_ff @(posedge clk_sys) begin
    if (sys_rst || soft_rst) begin
      pc_reg <= PC_RST;
    end else if (take && is_pop) begin
      pc_reg <= stk_top;
    end else if (take) begin
      pc_reg <= pc_reg + 15'h0001;
    end
  end

  // ************************************************************************
  // working register and carry
  // ************************************************************************
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      w_reg <= WREG_RST;
    end else if (take && is_lret) begin
      w_reg <= instr_word[7:0];
    end else if (take && is_rotl && !rot_to_f) begin
      w_reg <= rot_out;
    end else if (apb_wr && paddr == ADDR_WREG) begin
      w_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      carry_reg <= 1'b0;
    end else if (take && is_rotl) begin
      carry_reg <= rot_carry;
    end else if (apb_wr && paddr == ADDR_STATUS) begin
      carry_reg <= pwdata[CARRY_BIT];
    end
  end

  // rotate write-back wins over a bus write in the same cycle
  always_ff @(posedge clk_sys) begin
    if (take && is_rotl && rot_to_f) begin
      dmem[f_addr] <= rot_out;
    end else if (apb_wr && dmem_hit) begin
      dmem[paddr[8:2]] <= pwdata[7:0];
    end
  end

  // ************************************************************************
  // interrupt enable, reset flag, run control
  // ************************************************************************
  always_ff @(posedge clk_sys) begin
    if (sys_rst || soft_rst) begin
      int_en_reg <= INT_EN_RST;
    end else if (take && is_iret) begin
      int_en_reg <= 1'b1;
    end else if (apb_wr && paddr == ADDR_INTCTL) begin
      int_en_reg <= pwdata[INT_EN_BIT];
    end
  end

  // hardware clear wins: a reset must always be traceable
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rst_flag_reg <= RST_FLAG_RST;
    end else if (soft_rst) begin
      rst_flag_reg <= 1'b0;
    end else if (apb_wr && paddr == ADDR_PWRCTL) begin
      rst_flag_reg <= pwdata[RST_FLAG_BIT];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      run_reg <= RUN_RST;
    end else if (apb_wr && paddr == ADDR_CTRL) begin
      run_reg <= pwdata[RUN_BIT];
    end
  end

  // ************************************************************************
  // apb answer
  // ************************************************************************
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= '0;
    end else begin
      pready_reg  <= psel && penable && !pready_reg;
      pslverr_reg <= psel && penable && !pready_reg && !(reg_hit || dmem_hit);
      prdata_reg  <= '0;
      if (psel && penable && !pready_reg && !pwrite) begin
        if (dmem_hit) begin
          prdata_reg <= {24'h000000, dmem[paddr[8:2]]};
        end else begin
          case (paddr)
            ADDR_WREG:   prdata_reg <= {24'h000000, w_reg};
            ADDR_STATUS: prdata_reg <= {31'h00000000, carry_reg};
            ADDR_INTCTL: prdata_reg <= {24'h000000, int_en_reg, 7'h00};
            ADDR_PWRCTL: prdata_reg <= {29'h00000000, rst_flag_reg, 2'h0};
            ADDR_PC:     prdata_reg <= {17'h00000, pc_reg};
            ADDR_STKPTR: prdata_reg <= {28'h0000000, stk_depth};
            ADDR_CTRL:   prdata_reg <= {31'h00000000, run_reg};
            default:     prdata_reg <= '0;
          endcase
        end
      end
    end
  end

  assign prdata      = prdata_reg;
  assign pready      = pready_reg;
  assign pslverr     = pslverr_reg;
  assign instr_taken = taken_reg;
  assign pc_out      = pc_reg;
  assign w_out       = w_reg;
  assign carry_out   = carry_reg;
  assign global_interrupt_enable = int_en_reg;
  assign dev_rst_req = dev_rst_reg;

  // ************************************************************************
  // checks
  // ************************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  a_reset_clears_flag: assert property (soft_rst |=> !rst_flag_reg && dev_rst_reg && pc_reg == PC_RST)
    else $error("software reset did not clear flag or pulse reset");
  a_iret_pc_load: assert property (take && is_iret |=> pc_reg == $past(stk_top))
    else $error("interrupt return did not load pc from stack");
  a_iret_sets_enable: assert property (take && is_iret |=> int_en_reg && carry_reg == $past(carry_reg))
    else $error("interrupt return did not set interrupt enable");
  a_lret_loads_w: assert property (take && is_lret |=> w_reg == $past(instr_word[7:0]))
    else $error("literal return did not load w");
  a_lret_two_cyc: assert property (take && is_lret |=> pc_reg == $past(stk_top) ##1 (!take)[*6])
    else $error("literal return not two instruction cycles");
  a_return_keeps_w: assert property (take && is_return |=> w_reg == $past(w_reg)
                                     && carry_reg == $past(carry_reg) && pc_reg == $past(stk_top))
    else $error("return altered w or carry");
  a_rotl_carry_out: assert property (take && is_rotl |=> carry_reg == $past(rd_byte[7]))
    else $error("rotate carry wrong");
  a_rotl_dest_w: assert property (take && is_rotl && !rot_to_f
                                 |=> w_reg == {$past(rd_byte[6:0]), $past(carry_reg)})
    else $error("rotate to w wrong");
  a_nop_pc_step: assert property (take && is_nop |=> pc_reg == $past(pc_reg) + 15'h0001
                                  && w_reg == $past(w_reg) && state_reg == RRX_ST_EXEC)
    else $error("no-op changed state or pc");

  c_iret_seen:   cover property (take && is_iret);
  c_rotl_to_file: cover property (take && is_rotl && rot_to_f);
  c_soft_reset:  cover property (soft_rst);
endmodule : rrx_core

//--- testbench/rrx_fetch_model.sv
// fetch-stage model: offers one instruction word at a time to the executor
`timescale 1ns/100ps
module rrx_fetch_model (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        issue,
  input  wire logic [13:0] issue_word,
  input  wire logic        instr_taken,
  output logic             instr_valid,
  output logic [13:0]      instr_word
);
  // a released word shows its inverse, so a stale value never passes for a held one
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      instr_valid <= 1'b0;
      instr_word  <= 14'h3fff;
    end else if (issue) begin
      instr_valid <= 1'b1;
      instr_word  <= issue_word;
    end else if (instr_taken) begin
      instr_valid <= 1'b0;
      instr_word  <= ~instr_word;
    end
  end
endmodule : rrx_fetch_model

//--- testbench/test_return_reset_rotate_exec.sv
// self-checking bench for the return/reset/rotate executor
`timescale 1ns/100ps
module test_return_reset_rotate_exec;
  import rrx_pkg::*;
  logic clk_sys = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdv;
  logic pready, pslverr, instr_valid, instr_taken, dev_rst_req, global_interrupt_enable, carry_out, errv;
  logic issue = 1'b0, stack_push = 1'b0;
  logic [13:0] issue_word = 14'h0, instr_word;
  logic [PC_W-1:0] push_addr = '0, pc_out;
  logic [7:0] w_out;
  int num_errors = 0, tests_run = 0, cyc = 0, t0, t1, t2;

  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;

  rrx_core i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .instr_valid(instr_valid), .instr_word(instr_word), .stack_push(stack_push), .push_addr(push_addr),
    .instr_taken(instr_taken), .pc_out(pc_out), .w_out(w_out), .carry_out(carry_out),
    .global_interrupt_enable(global_interrupt_enable), .dev_rst_req(dev_rst_req));
  rrx_fetch_model i_fetch (.clk_sys(clk_sys), .sys_rst(sys_rst), .issue(issue), .issue_word(issue_word),
    .instr_taken(instr_taken), .instr_valid(instr_valid), .instr_word(instr_word));

  // ****************************************************************************
  // shared tasks
  // ****************************************************************************
  task automatic summarize();
    if (num_errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize

  task automatic check(string n, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask : check

  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge clk_sys); n++; end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin num_errors++; summarize(); end
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task automatic rd_chk(string n, logic [11:0] a, logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(n, rdv, e);
  endtask : rd_chk

  function automatic logic [11:0] dm(int f);
    return {ADDR_DMEM_HI, 8'h00} + 12'(4 * f);
  endfunction : dm

  // returns the cycle count at the edge where instr_taken is seen
  task automatic exec(logic [13:0] w, output int at);
    int n;
    @(posedge clk_sys);
    issue <= 1'b1; issue_word <= w;
    @(posedge clk_sys);
    issue <= 1'b0;
    n = 0;
    do begin @(posedge clk_sys); n++; end while (instr_taken !== 1'b1 && n < 40);
    if (n >= 40) begin num_errors++; summarize(); end
    at = cyc;
  endtask : exec

  task automatic push(logic [PC_W-1:0] a);
    @(posedge clk_sys);
    stack_push <= 1'b1; push_addr <= a;
    @(posedge clk_sys);
    stack_push <= 1'b0;
  endtask : push

  // ****************************************************************************
  // scenarios
  // ****************************************************************************
  task automatic t_reset_values();
    rd_chk("w", ADDR_WREG, 32'h0);
    rd_chk("status", ADDR_STATUS, 32'h0);
    rd_chk("intctl", ADDR_INTCTL, 32'h0);
    rd_chk("pwrctl", ADDR_PWRCTL, 32'h4);
    rd_chk("ctrl", ADDR_CTRL, 32'h1);
    rd_chk("depth", ADDR_STKPTR, 32'h0);
    apb(1'b0, 12'h01c, 32'h0);
    check("unmapped err", 32'(errv), 32'h1);
    apb(1'b1, 12'h002, 32'hff);
    check("misaligned err", 32'(errv), 32'h1);
  endtask : t_reset_values

  // run bit low must hold back a waiting word; pc is not writable over the bus
  task automatic t_stall();
    int n;
    apb(1'b1, ADDR_CTRL, 32'h0);
    @(posedge clk_sys);
    issue <= 1'b1;
    issue_word <= OP_NOP;
    @(posedge clk_sys);
    issue <= 1'b0;
    n = 0;
    repeat (12) begin
      @(posedge clk_sys);
      if (instr_taken !== 1'b0) n++;
    end
    check("stall takes", 32'(n), 32'h0);
    rd_chk("stall ctrl", ADDR_CTRL, 32'h0);
    apb(1'b1, ADDR_PC, 32'h55);
    check("pc write err", 32'(errv), 32'h0);
    apb(1'b1, ADDR_CTRL, 32'h1);
    n = 0;
    do begin @(posedge clk_sys); n++; end while (instr_taken !== 1'b1 && n < 40);
    if (n >= 40) begin num_errors++; summarize(); end
    check("resume pc", 32'(pc_out), 32'h1);
    rd_chk("pc read only", ADDR_PC, 32'h1);
  endtask : t_stall

  task automatic t_rotate();
    apb(1'b1, dm(5), 32'he6);
    apb(1'b1, ADDR_STATUS, 32'h0);
    exec({OP_ROTL_HI, 1'b0, 7'd5}, t0);
    check("rot w", 32'(w_out), 32'hcc);
    check("rot carry", 32'(carry_out), 32'h1);
    exec({OP_ROTL_HI, 1'b1, 7'd5}, t0);
    check("rot w kept", 32'(w_out), 32'hcc);
    rd_chk("rot f", dm(5), 32'hcd);
    apb(1'b1, dm(127), 32'h01);
    exec({OP_ROTL_HI, 1'b1, 7'd127}, t0);
    check("rot carry out0", 32'(carry_out), 32'h0);
    exec({OP_ROTL_HI, 1'b0, 7'd127}, t0);
    check("rot w2", 32'(w_out), 32'h06);
    rd_chk("rot f127", dm(127), 32'h03);
  endtask : t_rotate

  task automatic t_returns();
    push(15'h1234);
    apb(1'b1, ADDR_STATUS, 32'h1);
    exec({OP_LRET_HI, 8'h5a}, t0);
    check("litret pc", 32'(pc_out), 32'h1234);
    check("litret w", 32'(w_out), 32'h5a);
    check("litret carry", 32'(carry_out), 32'h1);
    exec(OP_NOP, t1);
    check("litret cycles", t1 - t0, 32'd8);
    check("nop pc", 32'(pc_out), 32'h1235);
    check("nop w", 32'(w_out), 32'h5a);
    exec(OP_NOP, t2);
    check("nop cycles", t2 - t1, 32'd4);
    push(15'h0100);
    apb(1'b1, ADDR_INTCTL, 32'h0);
    exec(OP_RETURN, t0);
    check("ret pc", 32'(pc_out), 32'h0100);
    check("ret w", 32'(w_out), 32'h5a);
    check("ret carry", 32'(carry_out), 32'h1);
    exec(OP_NOP, t1);
    check("ret cycles", t1 - t0, 32'd8);
    push(15'h0200);
    exec(OP_IRET, t0);
    check("reti pc", 32'(pc_out), 32'h0200);
    check("reti int enable", 32'(global_interrupt_enable), 32'h1);
    check("reti carry", 32'(carry_out), 32'h1);
    exec(OP_NOP, t1);
    check("reti cycles", t1 - t0, 32'd8);
    rd_chk("reti intctl", ADDR_INTCTL, 32'h80);
    rd_chk("depth empty", ADDR_STKPTR, 32'h0);
  endtask : t_returns

  task automatic t_soft_reset();
    push(15'h0077);
    push(15'h0055);
    exec(OP_RESET, t0);
    check("swrst req", 32'(dev_rst_req), 32'h1);
    check("swrst pc", 32'(pc_out), 32'h0);
    check("swrst int enable", 32'(global_interrupt_enable), 32'h0);
    rd_chk("swrst flag", ADDR_PWRCTL, 32'h0);
    rd_chk("swrst depth", ADDR_STKPTR, 32'h0);
  endtask : t_soft_reset

  // ****************************************************************************
  // main sequence
  // ****************************************************************************
  initial begin
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_reset_values();
    t_stall();
    t_rotate();
    t_returns();
    t_soft_reset();
    summarize();
  end
endmodule : test_return_reset_rotate_exec
